// ===== inc/sml_pkg.sv
package sml_pkg;

  // Register addresses on the plain access port
  localparam logic [7:0] ADDR_STATUS_MUTE   = 8'h17;
  localparam logic [7:0] ADDR_DYN_DELAY     = 8'h18;
  localparam logic [7:0] ADDR_REF_DETECT    = 8'h19;
  localparam logic [7:0] ADDR_LIVE_STATUS   = 8'h1A;
  localparam logic [7:0] ADDR_MARGIN_ACTIVE = 8'h1B;

  // Field positions
  localparam int MUTE0_BIT       = 0;
  localparam int MUTE1_BIT       = 1;
  localparam int CH0_1_BIT       = 0;
  localparam int CH2_3_BIT       = 1;
  localparam int CH4_BIT         = 2;
  localparam int CH5_BIT         = 3;
  localparam int CH6_BIT         = 4;
  localparam int CH7_BIT         = 5;
  localparam int PRI_DET_LSB     = 4;
  localparam int SEC_DET_LSB     = 6;
  localparam int LIVE_MUTE0_BIT  = 0;
  localparam int LIVE_MUTE1_BIT  = 1;
  localparam int LIVE_ENERGY_BIT = 2;
  localparam int LIVE_INVAL_BIT  = 3;

  // Values after reset
  localparam logic [7:0] RST_STATUS_MUTE = 8'h02;
  localparam logic [7:0] RST_DYN_DELAY   = 8'h00;
  localparam logic [7:0] RST_REF_DETECT  = 8'h50;

  // Writable bits; the rest read zero and ignore writes
  localparam logic [7:0] MASK_STATUS_MUTE = 8'h03;
  localparam logic [7:0] MASK_DYN_DELAY   = 8'h3F;
  localparam logic [7:0] MASK_REF_DETECT  = 8'hFF;

  // Divider groups and margining threshold
  localparam int               NUM_DIV        = 6;
  localparam int               DIV_W          = 8;
  localparam logic [DIV_W-1:0] MARGIN_MIN_DIV = 8'h08;

  // Energy detector observation window, in clock cycles
  localparam int         ENERGY_CNT_W   = 7;
  localparam logic [6:0] ENERGY_WIN_CYC = 7'h40;

  typedef enum logic [1:0] {
    DET_RISE  = 2'b00,
    DET_BOTH  = 2'b01,
    DET_FALL  = 2'b10,
    DET_LEVEL = 2'b11
  } sml_det_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sml_bus_s;

  typedef struct packed {
    logic carries_clock;
    logic level;
  } sml_pin_s;

endpackage

// ===== rtl/sml_pin_gate.sv
`timescale 1ns/10ps
module sml_pin_gate (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          ce,
  // Pin source and control
  input  wire sml_pkg::sml_pin_s pin,
  input  wire logic          mute_en,
  input  wire logic          ref_invalid,
  // Pin drive
  output logic               pin_out,
  output logic               pin_oe_n,
  output logic               muted
);
  import sml_pkg::*;

  logic muted_nxt;
  logic out_nxt;

  // Only a pin carrying a clock may be silenced
  assign muted_nxt = pin.carries_clock & mute_en & ref_invalid; // RULE1 RULE2 RULE3
  assign out_nxt   = muted_nxt ? 1'b0 : pin.level;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_out  <= 1'b0;
      pin_oe_n <= 1'b0;
      muted    <= 1'b0;
    end else if (ce) begin
      pin_out  <= out_nxt;
      pin_oe_n <= muted_nxt; // RULE1
      muted    <= muted_nxt;
    end
  end

endmodule

// ===== rtl/sml_energy_det.sv
`timescale 1ns/10ps
module sml_energy_det (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  // Reference and method
  input  wire logic             ref_in,
  input  wire sml_pkg::sml_det_e method,
  // Result
  output logic                  energy
);
  import sml_pkg::*;

  logic                    prev_r;
  logic                    seen_hi_r;
  logic                    seen_lo_r;
  logic [ENERGY_CNT_W-1:0] cnt_r;
  logic [ENERGY_CNT_W-1:0] cnt_nxt;
  logic                    rise;
  logic                    fall;
  logic                    hit;
  logic                    expire;

  assign rise = ref_in & ~prev_r;
  assign fall = ~ref_in & prev_r;

  // Level mode needs both a high and a low inside one window
  assign hit = (method == DET_RISE)  ? rise :          // RULE6
               (method == DET_BOTH)  ? (rise | fall) : // RULE7
               (method == DET_FALL)  ? fall :          // RULE7
               (seen_hi_r & seen_lo_r);                // RULE7
  assign expire  = (cnt_r == ENERGY_WIN_CYC - 7'h01);
  assign cnt_nxt = (hit | expire) ? '0 : cnt_r + 7'h01;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_r    <= 1'b0;
      seen_hi_r <= 1'b0;
      seen_lo_r <= 1'b0;
      cnt_r     <= '0;
      energy    <= 1'b0;
    end else if (ce) begin
      prev_r    <= ref_in;
      cnt_r     <= cnt_nxt;
      seen_hi_r <= (hit | expire) ? 1'b0 : (seen_hi_r | ref_in);
      seen_lo_r <= (hit | expire) ? 1'b0 : (seen_lo_r | ~ref_in);
      if (hit) begin
        energy <= 1'b1;
      end else if (expire) begin
        energy <= 1'b0;
      end
    end
  end

endmodule

// ===== rtl/sml_regs.sv
// Behaviour
// RULE1 - Clock-carrying status pin muted on invalid reference
// RULE2 - Mute bit zero keeps the pin driving
// RULE3 - Non-clock status pin ignores its mute bit
// RULE4 - Six margin enables act when divide exceeds eight
// RULE5 - Secondary detect method at bits 7:6, reset 1
// RULE6 - Method 0 uses rising-edge detection
// RULE7 - Methods 1-3: both edges, falling, level
// RULE8 - Reserved bits read zero, ignore writes
`timescale 1ns/10ps
module sml_regs (
  // Clock, reset, enable
  input  wire logic                                  clk,
  input  wire logic                                  rstn,
  input  wire logic                                  ce,
  // Register access
  input  wire sml_pkg::sml_bus_s                     bus,
  output logic [7:0]                                 rdata,
  // Reference state
  input  wire logic                                  sel_ref_invalid,
  input  wire logic                                  sec_ref_in,
  output logic                                       sec_energy,
  // Status pins
  input  wire sml_pkg::sml_pin_s                     first_status_pin,
  input  wire sml_pkg::sml_pin_s                     second_status_pin,
  output logic                                       first_status_pin_out,
  output logic                                       first_status_pin_oe_n,
  output logic                                       second_status_pin_out,
  output logic                                       second_status_pin_oe_n,
  // Output dividers
  input  wire logic [sml_pkg::NUM_DIV-1:0][sml_pkg::DIV_W-1:0] div_value,
  output logic [sml_pkg::NUM_DIV-1:0]                margin_active,
  // Detect configuration exported to the input stage
  output logic [1:0]                                 primary_detect_method,
  output sml_pkg::sml_det_e                          secondary_detect_method
);
  import sml_pkg::*;

  // Stored registers
  logic [7:0] status_pin_mute_control_r;
  logic [7:0] divider_dynamic_delay_enable_r;
  logic [7:0] reference_detect_control_r;
  logic [7:0] status_pin_mute_control_nxt;
  logic [7:0] divider_dynamic_delay_enable_nxt;
  logic [7:0] reference_detect_control_nxt;

  // Address decode
  logic hit_mute;
  logic hit_dyn;
  logic hit_ref;
  logic hit_live;
  logic hit_marg;
  logic wr_mute;
  logic wr_dyn;
  logic wr_ref;

  // Read path
  logic [7:0] rd_sel;
  logic [7:0] rdata_nxt;
  logic [7:0] live_status;

  // Named fields
  logic first_status_pin_mute_bit;
  logic second_status_pin_mute_bit;
  logic ch0_1_margin_enable;
  logic ch2_3_margin_enable;
  logic ch4_margin_enable;
  logic ch5_margin_enable;
  logic ch6_margin_enable;
  logic ch7_margin_enable;
  logic [NUM_DIV-1:0] margin_en;
  logic [NUM_DIV-1:0] margin_nxt;

  // Per-pin mute flags
  logic first_muted;
  logic second_muted;

  assign hit_mute = (bus.addr == ADDR_STATUS_MUTE);
  assign hit_dyn  = (bus.addr == ADDR_DYN_DELAY);
  assign hit_ref  = (bus.addr == ADDR_REF_DETECT);
  assign hit_live = (bus.addr == ADDR_LIVE_STATUS);
  assign hit_marg = (bus.addr == ADDR_MARGIN_ACTIVE);

  assign wr_mute = bus.wr & hit_mute;
  assign wr_dyn  = bus.wr & hit_dyn;
  assign wr_ref  = bus.wr & hit_ref;

  // Masking on write keeps reserved bits at zero in storage
  assign status_pin_mute_control_nxt = wr_mute ? (bus.wdata & MASK_STATUS_MUTE) // RULE8
                                               : status_pin_mute_control_r;
  assign divider_dynamic_delay_enable_nxt = wr_dyn ? (bus.wdata & MASK_DYN_DELAY) // RULE8
                                                   : divider_dynamic_delay_enable_r;
  assign reference_detect_control_nxt = wr_ref ? (bus.wdata & MASK_REF_DETECT)
                                               : reference_detect_control_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_pin_mute_control_r      <= RST_STATUS_MUTE;
      divider_dynamic_delay_enable_r <= RST_DYN_DELAY;
      reference_detect_control_r     <= RST_REF_DETECT; // RULE5
    end else if (ce) begin
      status_pin_mute_control_r      <= status_pin_mute_control_nxt;
      divider_dynamic_delay_enable_r <= divider_dynamic_delay_enable_nxt;
      reference_detect_control_r     <= reference_detect_control_nxt;
    end
  end

  // Field extraction
  assign first_status_pin_mute_bit  = status_pin_mute_control_r[MUTE0_BIT];
  assign second_status_pin_mute_bit = status_pin_mute_control_r[MUTE1_BIT];

  assign ch0_1_margin_enable = divider_dynamic_delay_enable_r[CH0_1_BIT]; // RULE4
  assign ch2_3_margin_enable = divider_dynamic_delay_enable_r[CH2_3_BIT]; // RULE4
  assign ch4_margin_enable   = divider_dynamic_delay_enable_r[CH4_BIT];   // RULE4
  assign ch5_margin_enable   = divider_dynamic_delay_enable_r[CH5_BIT];   // RULE4
  assign ch6_margin_enable   = divider_dynamic_delay_enable_r[CH6_BIT];   // RULE4
  assign ch7_margin_enable   = divider_dynamic_delay_enable_r[CH7_BIT];   // RULE4

  assign margin_en = {ch7_margin_enable, ch6_margin_enable, ch5_margin_enable,
                      ch4_margin_enable, ch2_3_margin_enable, ch0_1_margin_enable};

  // Small divides cannot be margined glitch-free, so the enable is held off
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DIV; gi++) begin : g_margin
      assign margin_nxt[gi] = margin_en[gi] & (div_value[gi] > MARGIN_MIN_DIV); // RULE4
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      margin_active <= '0;
    end else if (ce) begin
      margin_active <= margin_nxt;
    end
  end

  // Detect method fields
  assign primary_detect_method   = reference_detect_control_r[PRI_DET_LSB +: 2];
  assign secondary_detect_method = sml_det_e'(reference_detect_control_r[SEC_DET_LSB +: 2]); // RULE5

  // Status pin gating
  sml_pin_gate u_first_gate (
    .clk         (clk),
    .rstn        (rstn),
    .ce          (ce),
    .pin         (first_status_pin),
    .mute_en     (first_status_pin_mute_bit),
    .ref_invalid (sel_ref_invalid),
    .pin_out     (first_status_pin_out),
    .pin_oe_n    (first_status_pin_oe_n),
    .muted       (first_muted)
  );

  sml_pin_gate u_second_gate (
    .clk         (clk),
    .rstn        (rstn),
    .ce          (ce),
    .pin         (second_status_pin),
    .mute_en     (second_status_pin_mute_bit),
    .ref_invalid (sel_ref_invalid),
    .pin_out     (second_status_pin_out),
    .pin_oe_n    (second_status_pin_oe_n),
    .muted       (second_muted)
  );

  // Secondary reference energy detection
  sml_energy_det u_sec_det (
    .clk    (clk),
    .rstn   (rstn),
    .ce     (ce),
    .ref_in (sec_ref_in),
    .method (secondary_detect_method), // RULE6 RULE7
    .energy (sec_energy)
  );

  // Live state for software
  assign live_status = {4'h0, sel_ref_invalid, sec_energy, second_muted, first_muted};

  // Unmapped addresses read zero
  assign rd_sel = hit_mute ? status_pin_mute_control_r :
                  hit_dyn  ? divider_dynamic_delay_enable_r :
                  hit_ref  ? reference_detect_control_r :
                  hit_live ? live_status :
                  hit_marg ? {2'b00, margin_active} :
                  8'h00;

  // Data stand only in the cycle after the read strobe
  assign rdata_nxt = bus.rd ? rd_sel : 8'h00;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= rdata_nxt;
    end
  end

endmodule

// ===== tb/sml_regs_asserts.sv
`timescale 1ns/10ps
module sml_regs_asserts (
  // Clock, reset, enable
  input wire logic                                         clk,
  input wire logic                                         rstn,
  input wire logic                                         ce,
  // Register access
  input wire sml_pkg::sml_bus_s                            bus,
  input wire logic [7:0]                                   rdata,
  // Reference and detector
  input wire logic                                         sel_ref_invalid,
  input wire logic                                         sec_ref_in,
  input wire logic                                         sec_energy,
  input wire sml_pkg::sml_det_e                            secondary_detect_method,
  // Status pins
  input wire sml_pkg::sml_pin_s                            first_status_pin,
  input wire sml_pkg::sml_pin_s                            second_status_pin,
  input wire logic                                         first_status_pin_out,
  input wire logic                                         first_status_pin_oe_n,
  input wire logic                                         second_status_pin_oe_n,
  // Dividers
  input wire logic [sml_pkg::NUM_DIV-1:0][sml_pkg::DIV_W-1:0] div_value,
  input wire logic [sml_pkg::NUM_DIV-1:0]                  margin_active
);
  import sml_pkg::*;
  // Shadow of the writable fields, rebuilt from bus traffic
  logic [1:0] mute_r;
  logic [5:0] dyn_r;
  logic [1:0] sec_r;
  logic [5:0] gt;
  wire        m0 = first_status_pin.carries_clock && mute_r[0] && sel_ref_invalid;
  wire        m1 = second_status_pin.carries_clock && mute_r[1] && sel_ref_invalid;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mute_r <= 2'h2;
      dyn_r  <= 6'h00;
      sec_r  <= 2'h1;
    end else if (ce && bus.wr) begin
      if (bus.addr == ADDR_STATUS_MUTE) mute_r <= bus.wdata[1:0];
      if (bus.addr == ADDR_DYN_DELAY) dyn_r <= bus.wdata[5:0];
      if (bus.addr == ADDR_REF_DETECT) sec_r <= bus.wdata[7:6];
    end
  end
  always_comb begin
    for (int i = 0; i < NUM_DIV; i++) gt[i] = div_value[i] > MARGIN_MIN_DIV;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_mute_rd;
    ce && bus.rd && bus.addr == ADDR_STATUS_MUTE |=> rdata == {6'h00, mute_r};
  endproperty
  a_mute_rd: assert property (p_mute_rd) else $error("mute readback wrong");
  property p_dyn_rd;
    ce && bus.rd && bus.addr == ADDR_DYN_DELAY |=> rdata == {2'h0, dyn_r};
  endproperty
  a_dyn_rd: assert property (p_dyn_rd) else $error("margin readback wrong");
  property p_method;
    secondary_detect_method == sec_r;
  endproperty
  a_method: assert property (p_method) else $error("method field wrong");
  property p_pin0_mute;
    rstn && ce && m0 |=> first_status_pin_oe_n && !first_status_pin_out;
  endproperty
  a_pin0_mute: assert property (p_pin0_mute) else $error("pin0 not muted");
  property p_pin0_drive;
    // Sampled reset skips the release edge, where the flops still load reset values
    rstn && ce && !m0 |=> !first_status_pin_oe_n &&
      first_status_pin_out == $past(first_status_pin.level);
  endproperty
  a_pin0_drive: assert property (p_pin0_drive) else $error("pin0 not driven");
  property p_pin1;
    rstn && ce |=> second_status_pin_oe_n == $past(m1);
  endproperty
  a_pin1: assert property (p_pin1) else $error("pin1 enable wrong");
  property p_margin;
    rstn && ce |=> margin_active == $past(dyn_r & gt);
  endproperty
  a_margin: assert property (p_margin) else $error("margin wrong");
  property p_rise;
    ce && secondary_detect_method == DET_RISE && $rose(sec_ref_in) |=> sec_energy;
  endproperty
  a_rise: assert property (p_rise) else $error("rise missed");
  property p_fall;
    ce && secondary_detect_method == DET_FALL && $fell(sec_ref_in) |=> sec_energy;
  endproperty
  a_fall: assert property (p_fall) else $error("fall missed");
  cover property (ce && bus.wr && bus.addr == ADDR_STATUS_MUTE);
  cover property (ce && m0);
  cover property (sec_energy);
endmodule
bind sml_regs sml_regs_asserts u_chk (.clk, .rstn, .ce, .bus, .rdata, .sel_ref_invalid,
  .sec_ref_in, .sec_energy, .secondary_detect_method, .first_status_pin, .second_status_pin,
  .first_status_pin_out, .first_status_pin_oe_n, .second_status_pin_oe_n, .div_value,
  .margin_active);

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
  import sml_pkg::*;
  logic                          clk = 1'b0;
  logic                          rstn = 1'b0;
  logic                          ce = 1'b1;
  sml_bus_s                      bus = '0;
  logic                          sel_inv = 1'b0;
  logic                          sec_ref = 1'b0;
  sml_pin_s                      p0 = '0;
  sml_pin_s                      p1 = '0;
  logic [NUM_DIV-1:0][DIV_W-1:0] div = '0;
  logic [7:0]                    rdata;
  logic                          energy, o0, e0, o1, e1;
  logic [NUM_DIV-1:0]            marg;
  sml_det_e                      smeth;
  logic [1:0]                    pmeth;
  int                            fails = 0;
  int                            num_checks = 0;
  int                            cyc = 0;
  logic [7:0]                    q[$];
  logic                          rd_pend = 1'b0;
  sml_regs u_dut (.clk(clk), .rstn(rstn), .ce(ce), .bus(bus), .rdata(rdata),
    .sel_ref_invalid(sel_inv), .sec_ref_in(sec_ref), .sec_energy(energy),
    .first_status_pin(p0), .second_status_pin(p1), .first_status_pin_out(o0),
    .first_status_pin_oe_n(e0), .second_status_pin_out(o1), .second_status_pin_oe_n(e1),
    .div_value(div), .margin_active(marg), .primary_detect_method(pmeth),
    .secondary_detect_method(smeth));
  initial forever #25 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic op(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r);
    bus <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    op(a, 8'h00, 1'b0, 1'b1);
  endtask
  task automatic idle(input int n);
    repeat (n) op(8'h00, 8'h00, 1'b0, 1'b0);
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rd_pend) chk(rdata, q.pop_front());
    rd_pend <= bus.rd && ce;
    if (cyc == 3000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    logic       lv, c, mt, v, s;
    logic [7:0] d, dv;
    logic [5:0] en, ex;
    void'($urandom(14));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rd(ADDR_STATUS_MUTE, 8'h02);
    rd(ADDR_DYN_DELAY, 8'h00);
    rd(ADDR_REF_DETECT, 8'h50);
    op(ADDR_STATUS_MUTE, 8'hFF, 1'b1, 1'b0);
    rd(ADDR_STATUS_MUTE, 8'h03);
    op(ADDR_DYN_DELAY, 8'hFF, 1'b1, 1'b0);
    rd(ADDR_DYN_DELAY, 8'h3F);
    op(8'h20, 8'hFF, 1'b1, 1'b0);
    rd(8'h20, 8'h00);
    for (int i = 0; i < 8; i++) begin
      {v, mt, c} = 3'(i);
      lv = 1'($urandom);
      op(ADDR_STATUS_MUTE, {6'h00, mt, mt}, 1'b1, 1'b0);
      p0 <= '{c, lv};
      p1 <= '{~c, ~lv};
      sel_inv <= v;
      idle(2);
      #1;
      chk({7'h00, e0}, {7'h00, c & mt & v});
      chk({7'h00, o0}, {7'h00, lv & ~(c & mt & v)});
      chk({7'h00, e1}, {7'h00, ~c & mt & v});
      chk({7'h00, o1}, {7'h00, ~lv & ~(~c & mt & v)});
      rd(ADDR_LIVE_STATUS, {4'h0, v, 1'b0, ~c & mt & v, c & mt & v});
    end
    // Divide values 7, 8, 9 straddle the threshold
    for (int k = 0; k < 5; k++) begin
      en = 6'($urandom);
      for (int j = 0; j < NUM_DIV; j++) begin
        dv = (k < 3) ? 8'h07 + 8'(k) : 8'($urandom);
        div[j] <= dv;
        ex[j] = en[j] && dv > 8'h08;
      end
      op(ADDR_DYN_DELAY, {2'h0, en}, 1'b1, 1'b0);
      idle(2);
      #1;
      chk({2'h0, marg}, {2'h0, ex});
      rd(ADDR_MARGIN_ACTIVE, {2'h0, ex});
    end
    for (int m = 0; m < 4; m++) begin
      d = {2'(m), 6'($urandom)};
      s = (m != 2);
      op(ADDR_REF_DETECT, d, 1'b1, 1'b0);
      rd(ADDR_REF_DETECT, d);
      #1;
      chk({6'h00, smeth}, {6'h00, 2'(m)});
      chk({6'h00, pmeth}, {6'h00, d[5:4]});
      sec_ref <= s;
      idle(80);
      #1;
      chk({7'h00, energy}, 8'h00);
      sec_ref <= ~s;
      idle(3);
      #1;
      if (m == 0 || m == 2) chk({7'h00, energy}, 8'h00);
      sec_ref <= s;
      idle(3);
      #1;
      chk({7'h00, energy}, 8'h01);
    end
    // A frozen enable must swallow the write
    ce <= 1'b0;
    op(ADDR_DYN_DELAY, 8'h2A, 1'b1, 1'b0);
    idle(1);
    ce <= 1'b1;
    rd(ADDR_DYN_DELAY, {2'h0, en});
    idle(2);
    rstn <= 1'b0;
    idle(2);
    rstn <= 1'b1;
    rd(ADDR_STATUS_MUTE, 8'h02);
    rd(ADDR_REF_DETECT, 8'h50);
    idle(2);
    finish_test();
  end
endmodule
